/* hdl/r1ti_pkg.sv */
// constants of the remote-1 threshold adjust interval block
// assumes a 32-bit classic wishbone slave with one register per aligned word
`default_nettype none

package r1ti_pkg;

  // ==========================================================================
  // bus geometry
  localparam int          ADR_W      = 10;
  localparam int          DATA_W     = 32;
  localparam int          REG_W      = 8;

  // ==========================================================================
  // register indices, byte address is four times the index
  localparam logic [7:0]  IDX_INTERVAL = 8'h8e;
  localparam logic [7:0]  IDX_CONFIG   = 8'h90;
  localparam logic [7:0]  IDX_TMIN     = 8'h91;
  localparam logic [7:0]  IDX_STATUS   = 8'h92;

  // ==========================================================================
  // reset values
  localparam logic [7:0]  INTERVAL_RST = 8'h00;
  localparam logic [7:0]  CONFIG_RST   = 8'h00;
  localparam logic [7:0]  TMIN_RST     = 8'h00;

  // ==========================================================================
  // field positions
  localparam int          CODE_LSB       = 0;
  localparam int          CODE_W         = 3;
  localparam int          CFG_LOCK_BIT   = 0;
  localparam int          CFG_DYN_EN_BIT = 1;
  localparam int          STS_STATE_BIT  = 0;
  localparam int          STS_DEC_BIT    = 1;
  localparam int          STS_INC_BIT    = 2;

  // ==========================================================================
  // wait counts in monitoring cycles, doubled once per code step
  localparam int          CNT_W           = 12;
  localparam logic [11:0] DEC_BASE_CYCLES = 12'h008;
  localparam logic [11:0] INC_BASE_CYCLES = 12'h010;

  // ==========================================================================
  // threshold limits
  localparam logic [7:0]  TMIN_FLOOR = 8'h00;
  localparam logic [7:0]  TMIN_CEIL  = 8'hff;

  typedef enum logic [1:0] {
    R1TI_ST_OFF   = 2'b00,
    R1TI_ST_TRACK = 2'b01
  } r1ti_adj_e;

endpackage

`default_nettype wire

/* hdl/r1ti_reg_if.sv */
// register access carrier between the wishbone port and the register core
// assumes both ends run on the same clock
`default_nettype none

interface r1ti_reg_if;
  logic        req;
  logic        we;
  logic        lane_en;
  logic [7:0]  idx;
  logic [7:0]  wdata;
  logic [7:0]  rdata;

  modport port (output req, output we, output lane_en, output idx, output wdata, input rdata);
  modport core (input req, input we, input lane_en, input idx, input wdata, output rdata);
endinterface

`default_nettype wire

/* hdl/r1ti_interval_timer.sv */
// counts monitoring ticks and pulses when the coded wait has passed
// assumes tick is a one-cycle pulse on clk
`default_nettype none

module r1ti_interval_timer #(
  parameter int                          CW   = 12,
  parameter logic [CW-1:0]               BASE = 12'h008
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic                      tick,
  input  wire logic                      run,
  input  wire logic [2:0]                code,
  output logic                           expire_r
);

  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic          expire_nxt;
  logic [CW-1:0] limit;

  // ==========================================================================
  // wait length
  assign limit = BASE << code;

  always_comb begin
    count_nxt  = count_r;
    expire_nxt = 1'b0;
    if (!run) begin
      // a dropped request restarts the full wait
      count_nxt = '0;
    end else if (tick) begin
      if (count_r + 1'b1 >= limit) begin
        count_nxt  = '0;
        expire_nxt = 1'b1;
      end else begin
        count_nxt = count_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r  <= '0;
      expire_r <= 1'b0;
    end else if (ce) begin
      count_r  <= count_nxt;
      expire_r <= expire_nxt;
    end
  end

endmodule // r1ti_interval_timer

`default_nettype wire

/* hdl/r1ti_wb_port.sv */
// classic wishbone slave front end, one wait state then ack
// assumes the master holds the request until it samples ack
`default_nettype none

module r1ti_wb_port (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           ce,
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  input  wire logic                           wb_we_i,
  input  wire logic [r1ti_pkg::ADR_W-1:0]     wb_adr_i,
  input  wire logic [r1ti_pkg::DATA_W-1:0]    wb_dat_i,
  input  wire logic [3:0]                     wb_sel_i,
  output logic [r1ti_pkg::DATA_W-1:0]         wb_dat_r,
  output logic                                wb_ack_r,
  r1ti_reg_if.port                            rb
);

  logic                         ack_nxt;
  logic [r1ti_pkg::DATA_W-1:0]  dat_nxt;
  logic                         take;

  // ==========================================================================
  // request decode
  assign take       = wb_cyc_i & wb_stb_i & ~wb_ack_r;
  assign rb.req     = take;
  assign rb.we      = wb_we_i;
  assign rb.lane_en = wb_sel_i[0];
  assign rb.idx     = wb_adr_i[r1ti_pkg::ADR_W-1:2];
  assign rb.wdata   = wb_dat_i[7:0];

  always_comb begin
    ack_nxt = take;
    dat_nxt = wb_dat_r;
    if (take && !wb_we_i) begin
      dat_nxt = {24'h000000, rb.rdata};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_r <= 1'b0;
      wb_dat_r <= 32'h00000000;
    end else if (ce) begin
      wb_ack_r <= ack_nxt;
      wb_dat_r <= dat_nxt;
    end
  end

endmodule // r1ti_wb_port

`default_nettype wire

/* hdl/r1ti_top.sv */
// remote-1 fan-start threshold adjust interval register and pacing loop
// assumes monitor_tick, dec_req and inc_req come from logic on clk
`default_nettype none

// What this block does
// - interval register resets to zero
// - lock bit set makes interval register read-only
// - bits 2:0 hold the interval code
// - decrease wait is 8 cycles doubled per code
// - increase wait is 16 cycles doubled per code
// - adjustment only while dynamic enable is one
module r1ti_top (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           ce,
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  input  wire logic                           wb_we_i,
  input  wire logic [r1ti_pkg::ADR_W-1:0]     wb_adr_i,
  input  wire logic [r1ti_pkg::DATA_W-1:0]    wb_dat_i,
  input  wire logic [3:0]                     wb_sel_i,
  output logic [r1ti_pkg::DATA_W-1:0]         wb_dat_o,
  output logic                                wb_ack_o,
  input  wire logic                           monitor_tick,
  input  wire logic                           dec_req,
  input  wire logic                           inc_req,
  output logic [r1ti_pkg::REG_W-1:0]          tmin_current
);

  // ==========================================================================
  // declarations
  r1ti_reg_if rb ();

  logic [7:0]           interval_r;
  logic [7:0]           interval_nxt;
  logic                 lock_r;
  logic                 lock_nxt;
  logic                 dyn_en_r;
  logic                 dyn_en_nxt;
  logic [7:0]           tmin_prog_r;
  logic [7:0]           tmin_prog_nxt;
  logic [7:0]           tmin_r;
  logic [7:0]           tmin_nxt;
  r1ti_pkg::r1ti_adj_e  state_r;
  r1ti_pkg::r1ti_adj_e  state_nxt;
  logic [2:0]           remote1_adjust_interval_code;
  logic                 remote1_dyn_threshold_enable;
  logic                 wr;
  logic                 dec_run;
  logic                 inc_run;
  logic                 dec_expire;
  logic                 inc_expire;
  logic [7:0]           rdata;

  assign remote1_adjust_interval_code = interval_r[r1ti_pkg::CODE_LSB +: r1ti_pkg::CODE_W];
  assign remote1_dyn_threshold_enable = dyn_en_r;
  assign tmin_current                 = tmin_r;

  // ==========================================================================
  // bus front end
  r1ti_wb_port u_port (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_dat_i (wb_dat_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_r (wb_dat_o),
    .wb_ack_r (wb_ack_o),
    .rb       (rb.port)
  );

  assign wr = rb.req & rb.we & rb.lane_en;

  // ==========================================================================
  // read mux, unmapped indices read zero
  always_comb begin
    rdata = 8'h00;
    case (rb.idx)
      r1ti_pkg::IDX_INTERVAL: begin
        rdata = interval_r;
      end
      r1ti_pkg::IDX_CONFIG: begin
        rdata[r1ti_pkg::CFG_LOCK_BIT]   = lock_r;
        rdata[r1ti_pkg::CFG_DYN_EN_BIT] = dyn_en_r;
      end
      r1ti_pkg::IDX_TMIN: begin
        rdata = tmin_prog_r;
      end
      r1ti_pkg::IDX_STATUS: begin
        rdata[r1ti_pkg::STS_STATE_BIT] = (state_r == r1ti_pkg::R1TI_ST_TRACK);
        rdata[r1ti_pkg::STS_DEC_BIT]   = dec_run;
        rdata[r1ti_pkg::STS_INC_BIT]   = inc_run;
        rdata[7:3]                     = 5'h00;
      end
      default: begin
        rdata = 8'h00;
      end
    endcase
  end

  assign rb.rdata = rdata;

  // ==========================================================================
  // software registers
  always_comb begin
    interval_nxt  = interval_r;
    lock_nxt      = lock_r;
    dyn_en_nxt    = dyn_en_r;
    tmin_prog_nxt = tmin_prog_r;
    if (wr) begin
      case (rb.idx)
        r1ti_pkg::IDX_INTERVAL: begin
          // a locked register silently keeps its contents, the bus still acks
          if (!lock_r) begin
            interval_nxt = rb.wdata;
          end
        end
        r1ti_pkg::IDX_CONFIG: begin
          // lock is sticky until reset so software cannot undo it
          lock_nxt   = lock_r | rb.wdata[r1ti_pkg::CFG_LOCK_BIT];
          dyn_en_nxt = rb.wdata[r1ti_pkg::CFG_DYN_EN_BIT];
        end
        r1ti_pkg::IDX_TMIN: begin
          tmin_prog_nxt = rb.wdata;
        end
        default: begin
          interval_nxt = interval_r;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      interval_r  <= r1ti_pkg::INTERVAL_RST;
      lock_r      <= r1ti_pkg::CONFIG_RST[r1ti_pkg::CFG_LOCK_BIT];
      dyn_en_r    <= r1ti_pkg::CONFIG_RST[r1ti_pkg::CFG_DYN_EN_BIT];
      tmin_prog_r <= r1ti_pkg::TMIN_RST;
    end else if (ce) begin
      interval_r  <= interval_nxt;
      lock_r      <= lock_nxt;
      dyn_en_r    <= dyn_en_nxt;
      tmin_prog_r <= tmin_prog_nxt;
    end
  end

  // ==========================================================================
  // pacing timers, decrease wins when both requests are up
  assign dec_run = (state_r == r1ti_pkg::R1TI_ST_TRACK) & dec_req;
  assign inc_run = (state_r == r1ti_pkg::R1TI_ST_TRACK) & inc_req & ~dec_req;

  r1ti_interval_timer #(
    .CW   (r1ti_pkg::CNT_W),
    .BASE (r1ti_pkg::DEC_BASE_CYCLES)
  ) u_dec_timer (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .tick     (monitor_tick),
    .run      (dec_run),
    .code     (remote1_adjust_interval_code),
    .expire_r (dec_expire)
  );

  r1ti_interval_timer #(
    .CW   (r1ti_pkg::CNT_W),
    .BASE (r1ti_pkg::INC_BASE_CYCLES)
  ) u_inc_timer (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .tick     (monitor_tick),
    .run      (inc_run),
    .code     (remote1_adjust_interval_code),
    .expire_r (inc_expire)
  );

  // ==========================================================================
  // threshold engine
  always_comb begin
    state_nxt = state_r;
    tmin_nxt  = tmin_r;
    case (state_r)
      r1ti_pkg::R1TI_ST_OFF: begin
        // disabled: the threshold follows the programmed value
        tmin_nxt = tmin_prog_r;
        if (remote1_dyn_threshold_enable) begin
          state_nxt = r1ti_pkg::R1TI_ST_TRACK;
        end
      end
      r1ti_pkg::R1TI_ST_TRACK: begin
        if (!remote1_dyn_threshold_enable) begin
          state_nxt = r1ti_pkg::R1TI_ST_OFF;
          tmin_nxt  = tmin_prog_r;
        end else if (dec_expire && tmin_r != r1ti_pkg::TMIN_FLOOR) begin
          tmin_nxt = tmin_r - 8'h01;
        end else if (inc_expire && tmin_r != r1ti_pkg::TMIN_CEIL) begin
          tmin_nxt = tmin_r + 8'h01;
        end
      end
      default: begin
        state_nxt = r1ti_pkg::R1TI_ST_OFF;
        tmin_nxt  = tmin_prog_r;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= r1ti_pkg::R1TI_ST_OFF;
      tmin_r  <= r1ti_pkg::TMIN_RST;
    end else if (ce) begin
      state_r <= state_nxt;
      tmin_r  <= tmin_nxt;
    end
  end

endmodule // r1ti_top

`default_nettype wire

/* dv/r1ti_monitor.sv */
// port checker for the remote-1 interval block
// assumes one clock domain and an async active-high reset
`default_nettype none

module r1ti_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        monitor_tick,
  input wire logic [7:0]  tmin_current
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // shadow of interval and config
  logic       taken;
  logic       wr;
  logic [7:0] ivl_r;
  logic [7:0] ivl_nxt;
  logic [1:0] cfg_r;
  logic [1:0] cfg_nxt;
  logic       en_r;
  wire  logic [7:0] idx;
  assign idx = wb_adr_i[9:2];
  assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  assign wr = taken && wb_we_i && wb_sel_i[0];
  assign en_r = cfg_r[1];
  always_comb begin
    ivl_nxt = ivl_r;
    cfg_nxt = cfg_r;
    if (wr && idx == r1ti_pkg::IDX_INTERVAL && !cfg_r[0]) ivl_nxt = wb_dat_i[7:0];
    // lock can only be set, never cleared by software
    if (wr && idx == r1ti_pkg::IDX_CONFIG) cfg_nxt = {wb_dat_i[1], cfg_r[0] | wb_dat_i[0]};
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) {ivl_r, cfg_r} <= 10'h000;
    else {ivl_r, cfg_r} <= {ivl_nxt, cfg_nxt};
  end
  // ==========
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd_ivl;
    taken && !wb_we_i && idx == r1ti_pkg::IDX_INTERVAL;
  endsequence
  sequence s_tracking;
    en_r && $past(en_r) && !taken;
  endsequence
  a_ack_follow: assert property (taken |=> wb_ack_o) else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_o && ce |=> !wb_ack_o) else $error("ack too long");
  a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data set");
  a_read_ivl: assert property (s_rd_ivl |=> wb_dat_o == {24'h0, ivl_r})
    else $error("interval readback wrong");
  a_rst_clear: assert property ($fell(rst) |-> !wb_ack_o && tmin_current == 8'h00)
    else $error("state not cleared by reset");
  // a tick moves the threshold two edges later, so the quiet cycle is the one before
  a_tick_paced: assert property (s_tracking ##0 !$past(monitor_tick) |=> $stable(tmin_current))
    else $error("threshold moved without tick");
  a_step_one: assert property (s_tracking |=> (tmin_current - $past(tmin_current)) inside {8'h00, 8'h01, 8'hff})
    else $error("threshold step not one");
  // a programmed value written one cycle earlier still reaches the threshold
  a_off_hold: assert property (!en_r && !$past(en_r) && !$past(taken) |=> $stable(tmin_current))
    else $error("threshold moved while disabled");
endmodule // r1ti_monitor

bind r1ti_top r1ti_monitor i_r1ti_monitor (.clk, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .monitor_tick, .tmin_current);

`default_nettype wire

/* dv/r1ti_tb_top.sv */
// self-checking bench for the remote-1 interval block
// assumes the checker is bound in by its own file
`default_nettype none

module r1ti_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we_i = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] dat = 32'h0;
  logic        tick = 1'b0;
  logic        dec_req = 1'b0;
  logic        inc_req = 1'b0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [7:0]  tmin;
  logic [31:0] q;
  int          mismatches = 0;
  int          checked = 0;
  always #5 clk = ~clk;
  r1ti_top i_r1ti_top (.clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we_i),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack_o),
    .monitor_tick(tick), .dec_req(dec_req), .inc_req(inc_req), .tmin_current(tmin));
  // ==========
  // shared tasks
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk);
    {cyc, stb, we_i, sel, adr, dat} <= {2'b11, we, 4'hf, idx, 2'h0, 24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    {cyc, stb} <= 2'b00;
    if (ack_o !== 1'b1) begin
      mismatches++;
      print_verdict();
    end
  endtask
  // counts ticks until the threshold moves; tick every third cycle leaves room for the update
  task automatic meas(input logic up, input int exp);
    logic [7:0] t0;
    int n;
    @(posedge clk);
    {dec_req, inc_req} <= {!up, up};
    t0 = tmin;
    n = 0;
    while (tmin === t0 && n < 4100) begin
      @(posedge clk) tick <= 1'b1;
      @(posedge clk) tick <= 1'b0;
      n++;
      @(posedge clk);
      @(negedge clk);
    end
    if (tmin === t0) begin
      mismatches++;
      print_verdict();
    end
    chk(n, exp);
    chk({24'h0, tmin}, {24'h0, up ? t0 + 8'h01 : t0 - 8'h01});
    @(posedge clk) {dec_req, inc_req} <= 2'b00;
  endtask
  // ==========
  // scenarios
  task automatic t_reset;
    wb(1'b0, r1ti_pkg::IDX_INTERVAL, 8'h00);
    chk(q, 32'h0);
    wb(1'b0, 8'h00, 8'h00);
    chk(q, 32'h0);
    wb(1'b1, r1ti_pkg::IDX_INTERVAL, 8'hfd);
    wb(1'b0, r1ti_pkg::IDX_INTERVAL, 8'h00);
    chk(q, 32'h0000_00fd);
    $display("reset and access test done");
  endtask
  task automatic t_pace;
    wb(1'b1, r1ti_pkg::IDX_TMIN, 8'h80);
    wb(1'b1, r1ti_pkg::IDX_CONFIG, 8'h02);
    wb(1'b0, r1ti_pkg::IDX_STATUS, 8'h00);
    chk(q, 32'h0000_0001);
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, r1ti_pkg::IDX_INTERVAL, 8'(c));
      meas(1'b0, 8 << c);
      meas(1'b1, 16 << c);
    end
    $display("pacing test done");
  endtask
  task automatic t_off;
    // shortest wait, so a timer running while disabled would show within the ticks
    wb(1'b1, r1ti_pkg::IDX_INTERVAL, 8'h00);
    wb(1'b1, r1ti_pkg::IDX_CONFIG, 8'h00);
    @(posedge clk) dec_req <= 1'b1;
    repeat (20) begin
      @(posedge clk) tick <= 1'b1;
      @(posedge clk) tick <= 1'b0;
    end
    chk({24'h0, tmin}, 32'h0000_0080);
    wb(1'b0, r1ti_pkg::IDX_STATUS, 8'h00);
    chk(q, 32'h0000_0000);
    @(posedge clk) dec_req <= 1'b0;
    $display("disabled test done");
  endtask
  task automatic t_lock;
    wb(1'b1, r1ti_pkg::IDX_INTERVAL, 8'h05);
    wb(1'b1, r1ti_pkg::IDX_CONFIG, 8'h01);
    wb(1'b1, r1ti_pkg::IDX_INTERVAL, 8'h02);
    wb(1'b0, r1ti_pkg::IDX_INTERVAL, 8'h00);
    chk(q, 32'h0000_0005);
    wb(1'b1, r1ti_pkg::IDX_CONFIG, 8'h00);
    wb(1'b0, r1ti_pkg::IDX_CONFIG, 8'h00);
    chk(q, 32'h0000_0001);
    wb(1'b1, r1ti_pkg::IDX_INTERVAL, 8'h03);
    wb(1'b0, r1ti_pkg::IDX_INTERVAL, 8'h00);
    chk(q, 32'h0000_0005);
    $display("lock test done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_pace();
    t_off();
    t_lock();
    print_verdict();
  end
endmodule // r1ti_tb_top

`default_nettype wire
